// ===== core/adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// ****************************************************************
// Register map (word addresses, 32-bit data)
// ****************************************************************
`define ADDR_CONTROL      4'h0
`define ADDR_STATUS       4'h1
`define ADDR_IRQ_STATUS   4'h2
`define ADDR_IRQ_MASK     4'h3
`define ADDR_TRACKING     4'h4
`define ADDR_RESULT_BASE  4'h8
`define ADDR_WIDTH        4

// ****************************************************************
// Control word fields
// ****************************************************************
`define CTRL_MODE_LO      3
`define CTRL_MODE_HI      4
`define CTRL_RESET        2'h0

`define MODE_SIMULTANEOUS 2'h0
`define MODE_SEQUENTIAL   2'h1
`define MODE_OFFSET_CAL   2'h2
`define MODE_GAIN_CAL     2'h3

// ****************************************************************
// Status word fields
// ****************************************************************
`define STAT_PAIR_LO      0
`define STAT_PAIR_HI      3
`define STAT_RANGE        4
`define STAT_RESET        5'h00

// Interrupt status bits
`define IRQ_END_SEQ       0
`define IRQ_RESET         1'h0

// ****************************************************************
// Converter data format
// ****************************************************************
`define RESULT_WIDTH      16
`define CHANNELS          8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS     20
`define CONV_CLK_TICKS    4
`define PAIR_SPACING      8
`define SEQ_SAMPLE_SPACING 4
`define CONV_LATENCY      14
`define SEQ_LIMIT         49
`define SEQ_TICK_W        6
`define SEQ_END_TICK      6'd44

// Input multiplexer routing
`define ROUTE_TRACK       2'h0
`define ROUTE_SEQUENCE    2'h1
`define ROUTE_REFERENCE   2'h2
`define ROUTE_GAIN        2'h3

`endif

// ===== core/result_store.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"

// ****************************************************************
// Eight-word result memory with registered read port
// ****************************************************************
module result_store (
    input  wire                     clk_in,
    input  wire                     wr_en_in,
    input  wire [2:0]               wr_addr_in,
    input  wire [`RESULT_WIDTH-1:0] wr_data_in,
    input  wire [2:0]               rd_addr_in,
    output reg  [`RESULT_WIDTH-1:0] rd_data_out
);

    reg [`RESULT_WIDTH-1:0] mem [0:`CHANNELS-1];

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end

endmodule
`default_nettype wire

// ===== core/adc_conversion_sequencer.v
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"

module adc_conversion_sequencer (
    input  wire                     clk_sys_in,
    input  wire                     rst_b_in,
    input  wire [`ADDR_WIDTH-1:0]   addr_in,
    input  wire [31:0]              wr_data_in,
    input  wire                     wr_en_in,
    input  wire                     rd_en_in,
    output reg  [31:0]              rd_data_out,
    input  wire                     convert_start_in,
    input  wire [`RESULT_WIDTH-1:0] core_data_in,
    input  wire                     out_of_range_flag_in,
    output reg  [2:0]               sample_channel_a_out,
    output reg  [2:0]               sample_channel_b_out,
    output reg                      sample_strobe_out,
    output reg  [1:0]               input_route_out,
    output reg                      sequence_active_out,
    output wire                     irq_out
);

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    reg rst_meta;
    reg rst_sync;

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_TRACK = 2'b01;
    localparam [1:0] ST_SEQ   = 2'b10;

    reg [1:0]               state;
    reg [1:0]               next_state;
    reg [1:0]               control_mode;
    reg [1:0]               run_mode;
    reg [`SEQ_TICK_W-1:0]   tick;
    reg [1:0]               conv_phase;
    reg                     start_prev;
    reg [4:0]               status;
    reg [7:0]               otr_bits;
    reg [`RESULT_WIDTH-1:0] tracking_result;
    reg                     irq_status;
    reg                     irq_mask;

    wire start_edge = convert_start_in && !start_prev;
    wire in_seq     = state[1];
    wire conv_tick  = (conv_phase == 2'd3);

    // ****************************************************************
    // Schedule helpers
    // ****************************************************************
    // Tick-wide copies keep schedule arithmetic at tick width
    localparam [`SEQ_TICK_W-1:0] SEQ_STEP  = `SEQ_SAMPLE_SPACING;
    localparam [`SEQ_TICK_W-1:0] PAIR_STEP = `PAIR_SPACING;
    localparam [`SEQ_TICK_W-1:0] LATENCY   = `CONV_LATENCY;

    // Result for slot k lands CONV_LATENCY after its sample tick, one converter clock later still for slots 4-7 in pair modes
    function [`SEQ_TICK_W-1:0] sample_tick;
        input [1:0] mode;
        input [2:0] ch;
        begin
            if (mode == `MODE_SEQUENTIAL) begin
                sample_tick = {3'b000, ch} * SEQ_STEP;
            end else begin
                sample_tick = {4'b0000, ch[1:0]} * PAIR_STEP;
            end
        end
    endfunction

    // Channel whose result is written at a given tick (second half
    // of a pair is one converter clock behind the first)
    function [3:0] result_slot;
        input [1:0]             mode;
        input [`SEQ_TICK_W-1:0] t;
        reg   [`SEQ_TICK_W-1:0] rel;
        begin
            rel = t - LATENCY;
            result_slot = 4'h8;
            if (t >= LATENCY && rel[1:0] == 2'b00) begin
                if (mode == `MODE_SEQUENTIAL) begin
                    if (rel[5:2] < 4'd8) begin
                        result_slot = {1'b0, rel[4:2]};
                    end
                end else if (rel[5:2] < 4'd8) begin
                    result_slot = {1'b0, rel[2], rel[4:3]};
                end
            end
        end
    endfunction

    wire [3:0] slot = result_slot(run_mode, tick);
    wire       slot_valid = in_seq && !slot[3];
    wire       last_done  = slot_valid && (slot[2:0] == 3'd7);

    // ****************************************************************
    // Sequence state machine
    // ****************************************************************
    always @* begin
        next_state = state;
        case (state)
            ST_TRACK: begin
                if (start_edge) begin
                    next_state = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (last_done) begin
                    next_state = ST_TRACK;
                end
            end
            default: begin
                next_state = ST_TRACK;
            end
        endcase
    end

    always @(posedge clk_sys_in or negedge rst_sync) begin
        if (!rst_sync) begin
            state      <= ST_TRACK;
            run_mode   <= `MODE_SIMULTANEOUS;
            tick       <= {`SEQ_TICK_W{1'b0}};
            conv_phase <= 2'd0;
            start_prev <= 1'b0;
        end else begin
            state      <= next_state;
            start_prev <= convert_start_in;
            conv_phase <= conv_phase + 2'd1;
            if (state == ST_TRACK && start_edge) begin
                run_mode <= control_mode;
                tick     <= {`SEQ_TICK_W{1'b0}};
            end else if (in_seq) begin
                tick <= tick + 6'd1;
            end
        end
    end

    // ****************************************************************
    // Sample multiplexer drive
    // ****************************************************************
    integer k;
    always @(posedge clk_sys_in or negedge rst_sync) begin
        if (!rst_sync) begin
            sample_channel_a_out <= 3'd0;
            sample_channel_b_out <= 3'd4;
            sample_strobe_out    <= 1'b0;
            input_route_out      <= `ROUTE_TRACK;
            sequence_active_out  <= 1'b0;
        end else begin
            sequence_active_out <= (next_state == ST_SEQ);
            sample_strobe_out   <= 1'b0;
            if (next_state == ST_SEQ) begin
                case (in_seq ? run_mode : control_mode)
                    `MODE_OFFSET_CAL: begin
                        input_route_out <= `ROUTE_REFERENCE;
                    end
                    `MODE_GAIN_CAL: begin
                        input_route_out <= `ROUTE_GAIN;
                    end
                    default: begin
                        input_route_out <= `ROUTE_SEQUENCE;
                    end
                endcase
                for (k = 0; k < 8; k = k + 1) begin
                    if ((in_seq ? tick + 6'd1 : 6'd0) ==
                        sample_tick(in_seq ? run_mode : control_mode,
                                    k[2:0])) begin
                        if ((in_seq ? run_mode : control_mode) ==
                            `MODE_SEQUENTIAL) begin
                            sample_channel_a_out <= k[2:0];
                            sample_strobe_out    <= 1'b1;
                        end else if (k < 4) begin
                            sample_channel_a_out <= k[2:0];
                            sample_channel_b_out <= k[2:0] + 3'd4;
                            sample_strobe_out    <= 1'b1;
                        end
                    end
                end
            end else begin
                input_route_out      <= `ROUTE_TRACK;
                sample_channel_a_out <= 3'd0;
                sample_channel_b_out <= 3'd4;
                sample_strobe_out    <= conv_tick;
            end
        end
    end

    // ****************************************************************
    // Result memory
    // ****************************************************************
    wire [`RESULT_WIDTH-1:0] mem_rd_data;
    wire                     rd_result = (addr_in >= `ADDR_RESULT_BASE);

    result_store u_result_store (
        .clk_in      (clk_sys_in),
        .wr_en_in    (slot_valid),
        .wr_addr_in  (slot[2:0]),
        .wr_data_in  (core_data_in),
        .rd_addr_in  (addr_in[2:0]),
        .rd_data_out (mem_rd_data)
    );

    // ****************************************************************
    // Status, tracking and interrupt
    // ****************************************************************
    wire pair_done = slot_valid && slot[2] &&
                     (run_mode != `MODE_SEQUENTIAL);
    wire irq_set   = last_done;
    wire irq_clr   = wr_en_in && (addr_in == `ADDR_IRQ_STATUS) &&
                     wr_data_in[`IRQ_END_SEQ];

    always @(posedge clk_sys_in or negedge rst_sync) begin
        if (!rst_sync) begin
            control_mode    <= `CTRL_RESET;
            status          <= `STAT_RESET;
            otr_bits        <= 8'h00;
            tracking_result <= {`RESULT_WIDTH{1'b0}};
            irq_status      <= `IRQ_RESET;
            irq_mask        <= 1'b0;
        end else begin
            if (wr_en_in && addr_in == `ADDR_CONTROL) begin
                control_mode <= wr_data_in[`CTRL_MODE_HI:`CTRL_MODE_LO];
            end else if (wr_en_in && addr_in == `ADDR_IRQ_MASK) begin
                irq_mask <= wr_data_in[`IRQ_END_SEQ];
            end
            if (state == ST_TRACK && start_edge) begin
                status[`STAT_PAIR_HI:`STAT_PAIR_LO] <= 4'h0;
                otr_bits <= 8'h00;
            end else if (pair_done) begin
                status[slot[1:0]] <= 1'b1;
            end else if (last_done && run_mode == `MODE_SEQUENTIAL) begin
                status[`STAT_PAIR_HI:`STAT_PAIR_LO] <= 4'hF;
            end
            if (slot_valid) begin
                otr_bits[slot[2:0]] <= out_of_range_flag_in;
            end
            if (state == ST_TRACK && conv_tick && !start_edge) begin
                tracking_result      <= core_data_in;
                status[`STAT_RANGE]  <= out_of_range_flag_in;
            end
            if (irq_set) begin
                irq_status <= 1'b1;
            end else if (irq_clr) begin
                irq_status <= 1'b0;
            end
        end
    end

    assign irq_out = irq_status && irq_mask;

    // ****************************************************************
    // Register read port
    // ****************************************************************
    reg       rd_pending;
    reg       rd_from_mem;
    reg [31:0] rd_word;

    always @(posedge clk_sys_in or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_pending  <= 1'b0;
            rd_from_mem <= 1'b0;
            rd_word     <= 32'h00000000;
        end else begin
            rd_pending  <= rd_en_in;
            rd_from_mem <= rd_en_in && rd_result;
            if (!rd_en_in) begin
                rd_word <= 32'h00000000;
            end else if (addr_in == `ADDR_CONTROL) begin
                rd_word <= {27'h0, control_mode, 3'h0};
            end else if (addr_in == `ADDR_STATUS) begin
                rd_word <= {19'h0, otr_bits, status};
            end else if (addr_in == `ADDR_IRQ_STATUS) begin
                rd_word <= {31'h0, irq_status};
            end else if (addr_in == `ADDR_IRQ_MASK) begin
                rd_word <= {31'h0, irq_mask};
            end else if (addr_in == `ADDR_TRACKING) begin
                rd_word <= {16'h0, tracking_result};
            end else begin
                rd_word <= 32'h00000000;
            end
        end
    end

    always @* begin
        if (rd_from_mem) begin
            rd_data_out = {16'h0000, mem_rd_data};
        end else if (rd_pending) begin
            rd_data_out = rd_word;
        end else begin
            rd_data_out = 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/adc_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"

// ****************************************
// Sequencer port checks
// ****************************************
module adc_seq_asserts (
    input wire logic        clk_sys_in,
    input wire logic        rst_b_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [31:0] rd_data_out,
    input wire logic        convert_start_in,
    input wire logic [2:0]  sample_channel_a_out,
    input wire logic        sample_strobe_out,
    input wire logic [1:0]  input_route_out,
    input wire logic        sequence_active_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
        else $error("read data not zero outside read");
    a_start_runs: assert property (
        $rose(convert_start_in) && !sequence_active_out
        |-> ##[1:6] sequence_active_out) else $error("start not taken");
    a_seq_bounded: assert property ($rose(sequence_active_out)
        |-> ##[1:49] !sequence_active_out) else $error("sequence too long");
    a_seq_minimum: assert property ($rose(sequence_active_out)
        |-> sequence_active_out[*8]) else $error("sequence too short");
    a_irq_cause: assert property ($rose(irq_out)
        |-> $past(wr_en_in) || sequence_active_out
        || $past(sequence_active_out)) else $error("irq from tracking");
    a_end_track: assert property ($fell(sequence_active_out)
        |-> ##[0:2] input_route_out == `ROUTE_TRACK)
        else $error("no return to tracking");
    a_seq_route: assert property (
        sample_strobe_out && sequence_active_out
        |-> input_route_out != `ROUTE_TRACK) else $error("route in sequence");
    a_track_ch0: assert property (
        sample_strobe_out && !sequence_active_out
        && !$past(sequence_active_out)
        |-> sample_channel_a_out == 3'h0 && input_route_out == `ROUTE_TRACK)
        else $error("tracking not on input 0");
    a_strobe_gap: assert property (
        sample_strobe_out && sequence_active_out
        |=> !sample_strobe_out [*3]) else $error("samples too close");

    cover property ($fell(sequence_active_out));
    cover property ($rose(irq_out));
    cover property (input_route_out == `ROUTE_GAIN);
    cover property (input_route_out == `ROUTE_REFERENCE);
endmodule

bind adc_conversion_sequencer adc_seq_asserts chk_u (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .convert_start_in(convert_start_in),
    .sample_channel_a_out(sample_channel_a_out),
    .sample_strobe_out(sample_strobe_out), .input_route_out(input_route_out),
    .sequence_active_out(sequence_active_out), .irq_out(irq_out));

`default_nettype wire

// ===== testbench/converter_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Converter core: new left-aligned code each clock
// ****************************************
module converter_core_model (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        range_bad_in,
    output logic      [15:0] core_data_out,
    output logic             out_of_range_out
);
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_data_out <= 16'h8000;
            out_of_range_out <= 1'b0;
        end else begin
            core_data_out <= core_data_out + 16'h0130;
            out_of_range_out <= range_bad_in;
        end
    end
endmodule

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"

module tb;
    logic        clk_sys_in;
    logic        rst_b_in;
    logic [3:0]  addr_in;
    logic [31:0] wr_data_in;
    logic        wr_en_in;
    logic        rd_en_in;
    logic        convert_start_in;
    logic        range_bad;
    logic [31:0] rd_data_out;
    logic [15:0] core_data;
    logic        core_oor;
    logic [2:0]  ch_a;
    logic [2:0]  ch_b;
    logic        strobe;
    logic        active;
    logic        irq;
    logic [1:0]  route;
    integer      errors;
    integer      checks_done;
    integer      cyc;
    integer      irq_cyc;
    integer      t0;
    logic [2:0]  qa[$];
    logic [2:0]  qb[$];
    logic [1:0]  qr[$];
    integer      qc[$];

    adc_conversion_sequencer dut_u (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .convert_start_in(convert_start_in), .core_data_in(core_data),
        .out_of_range_flag_in(core_oor), .sample_channel_a_out(ch_a),
        .sample_channel_b_out(ch_b), .sample_strobe_out(strobe),
        .input_route_out(route), .sequence_active_out(active),
        .irq_out(irq));
    converter_core_model core_u (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
        .range_bad_in(range_bad), .core_data_out(core_data),
        .out_of_range_out(core_oor));

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // ****************************************
    // Sample monitor
    // ****************************************
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (strobe && active) begin
            qa.push_back(ch_a);
            qb.push_back(ch_b);
            qr.push_back(route);
            qc.push_back(cyc);
        end
        if (irq === 1'b1 && irq_cyc < 0)
            irq_cyc <= cyc;
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task cmp_word(input string what, input logic [31:0] e,
                  input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task cmp_bit(input string what, input logic e, input logic g);
        cmp_word(what, {31'h0, e}, {31'h0, g});
    endtask
    task bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_en_in <= 1'b0;
        #1;
    endtask
    task bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic run_seq(input logic [1:0] mode, input logic [1:0] rt,
                           input logic [3:0] mid, input integer n, gap);
        logic [31:0] d;
        logic [31:0] t1;
        logic [31:0] r0;
        integer      i;
        bus_write(`ADDR_CONTROL, {27'h0, mode, 3'h0});
        bus_write(`ADDR_IRQ_STATUS, 32'h1);
        qa.delete();
        qb.delete();
        qr.delete();
        qc.delete();
        irq_cyc = -1;
        @(posedge clk_sys_in) convert_start_in <= 1'b1;
        #1 t0 = cyc;
        repeat (8) @(posedge clk_sys_in);
        bus_read(`ADDR_TRACKING, t1);
        repeat (8) @(posedge clk_sys_in);
        bus_read(`ADDR_TRACKING, d);
        cmp_word("tracking frozen", t1, d);
        bus_write(`ADDR_CONTROL, {27'h0, ~mode, 3'h0});
        @(posedge clk_sys_in) convert_start_in <= 1'b0;
        @(posedge clk_sys_in) convert_start_in <= 1'b1;
        repeat (7) @(posedge clk_sys_in);
        bus_read(`ADDR_STATUS, d);
        cmp_word("mid status", {28'h0, mid}, d & 32'h1FFF);
        for (i = 0; i < 60 && active; i++)
            @(posedge clk_sys_in);
        convert_start_in <= 1'b0;
        bus_read(`ADDR_STATUS, d);
        cmp_word("end status", 32'hF, d & 32'h1FFF);
        cmp_bit("irq", 1'b1, irq);
        cmp_bit("irq time", 1'b1, irq_cyc >= 0 && irq_cyc - t0 <= 49);
        bus_read(`ADDR_RESULT_BASE, r0);
        bus_read(`ADDR_RESULT_BASE + 4'h1, d);
        cmp_word("result step", gap * 32'h130,
                 {16'h0, d[15:0] - r0[15:0]});
        bus_read(`ADDR_RESULT_BASE + 4'h7, d);
        cmp_word("result span", 32'h2140,
                 {16'h0, d[15:0] - r0[15:0]});
        cmp_word("samples", n, qa.size());
        for (i = 0; i < qa.size(); i++) begin
            cmp_word("route", rt, qr[i]);
            if (i > 0)
                cmp_word("gap", gap, qc[i] - qc[i - 1]);
            if (mode < 2)
                cmp_word("chan a", i, qa[i]);
            if (mode == 0)
                cmp_word("chan b", i + 4, qb[i]);
        end
    endtask

    task irq_test;
        logic [31:0] d;
        bus_write(`ADDR_IRQ_MASK, 32'h0);
        cmp_bit("irq masked", 1'b0, irq);
        bus_read(`ADDR_IRQ_STATUS, d);
        cmp_word("irq sticky", 32'h1, d);
        bus_write(`ADDR_IRQ_MASK, 32'h1);
        cmp_bit("irq unmasked", 1'b1, irq);
        bus_write(`ADDR_IRQ_STATUS, 32'h1);
        cmp_bit("irq cleared", 1'b0, irq);
    endtask

    task track_test;
        logic [31:0] d;
        logic [31:0] t1;
        bus_read(`ADDR_TRACKING, t1);
        repeat (8) @(posedge clk_sys_in);
        bus_read(`ADDR_TRACKING, d);
        cmp_bit("tracking moves", 1'b1, t1 !== d);
        bus_write(`ADDR_IRQ_STATUS, 32'h1);
        @(posedge clk_sys_in) range_bad <= 1'b1;
        repeat (24) @(posedge clk_sys_in);
        bus_read(`ADDR_STATUS, d);
        cmp_word("range set", 32'h1F, d & 32'h1FFF);
        @(posedge clk_sys_in) range_bad <= 1'b0;
        repeat (24) @(posedge clk_sys_in);
        bus_read(`ADDR_STATUS, d);
        cmp_word("range clear", 32'hF, d & 32'h1FFF);
        cmp_bit("no irq", 1'b0, irq);
    endtask

    task reset_test;
        logic [31:0] d;
        bus_read(`ADDR_CONTROL, d);
        cmp_word("control reset", 32'h0, d);
        bus_write(4'h7, 32'hFFFFFFFF);
        bus_read(4'h7, d);
        cmp_word("unmapped", 32'h0, d);
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        errors = 0;
        checks_done = 0;
        cyc = 0;
        irq_cyc = -1;
        rst_b_in = 1'b0;
        addr_in = 4'h0;
        wr_data_in = 32'h0;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        convert_start_in = 1'b0;
        range_bad = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        reset_test;
        bus_write(`ADDR_IRQ_MASK, 32'h1);
        run_seq(`MODE_SIMULTANEOUS, `ROUTE_SEQUENCE, 4'h3, 4, 8);
        irq_test;
        run_seq(`MODE_SEQUENTIAL, `ROUTE_SEQUENCE, 4'h0, 8, 4);
        track_test;
        run_seq(`MODE_OFFSET_CAL, `ROUTE_REFERENCE, 4'h3, 4, 8);
        run_seq(`MODE_GAIN_CAL, `ROUTE_GAIN, 4'h3, 4, 8);
        report_and_stop;
    end

    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
endmodule

`default_nettype wire
